/* common/das_pkg.sv */
/*
  constants, register map and state types for the converter host bus control.
  assumes one 10 MHz clock (aclk) and an axi4-lite master for the register file.
*/
// Notes on behaviour
// RQ1 - byte-format select level at conversion start picks 8-bit (high) or 12-bit (low)
// RQ2 - result read with byte-format select low drives the eight top result bits
// RQ3 - result read with select high drives four low bits, zeros elsewhere
// RQ4 - channel latch and conversion start act on write strobe rising edge
// RQ5 - host not watching status waits about 35 us before reading
// RQ6 - host may use conversion status as wait/halt or interrupt request
// RQ7 - host may map the converter as memory or as an i/o device
// RQ8 - selected write, upper address low latches channel; high starts conversion (the code ignores a high write while a conversion runs)
// RQ9 - host sets channel before each start, allowing up to 10 us settling
// RQ10 - result bus released whenever no read is in progress
// RQ11 - next channel may be latched while a conversion still runs
package das_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int CONV12_TIME_NS = 35_000;
  localparam int CONV8_TIME_NS = 25_000;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CONV12_CYC = CNT_W'(CONV12_TIME_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CONV8_CYC = CNT_W'(CONV8_TIME_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_LAST = 9'h001;

  // ==========================================================
  // data widths
  localparam int RESULT_W = 12;
  localparam int BYTE_W = 8;
  localparam int CHAN_W = 3;
  localparam int LOW_NIB_W = 4;
  localparam logic [LOW_NIB_W-1:0] ZERO_NIB = 4'h0;

  // ==========================================================
  // host pin synchroniser lanes
  localparam int SYNC_W = 8;
  localparam int SY_WR = 0;
  localparam int SY_RD = 1;
  localparam int SY_SEL = 2;
  localparam int SY_AHI = 3;
  localparam int SY_BFS = 4;
  localparam int SY_DAT = 5;
  localparam logic [SYNC_W-1:0] SYNC_INIT = 8'h07;

  // ==========================================================
  // axi4-lite register map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // event bits, shared by status and mask
  localparam int EV_W = 2;
  localparam int EV_DONE = 0;
  localparam int EV_OVERLAP = 1;

  // result register fields
  localparam int RES_CHAN_LSB = 12;
  localparam int RES_SHORT_BIT = 15;
  localparam int RES_BUSY_BIT = 16;

  // control register
  localparam int CTL_HOST_EN = 0;
  localparam logic CTL_HOST_EN_RST = 1'b1;

  typedef enum logic {ST_IDLE = 1'b0, ST_CONV = 1'b1} conv_state_t;

endpackage

/* design/pin_sync.sv */
/*
  three-stage synchroniser for asynchronous host pins.
  the output only follows once stages two and three agree, so a
  glitch held for one sample is not passed on. stage one feeds stage two only.
*/
module pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] stable
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // ==========================================================
  // per-lane agreement filter
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      always_comb begin
        out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      out_q <= INIT;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign stable = out_q;

endmodule

/* design/das_host_bus_control.sv */
/*
  host bus control for an eight-channel 12-bit acquisition converter:
  decodes host strobes into channel latch, conversion start and byte reads,
  times the conversion and raises conversion status, with an axi4-lite
  register file for events, mask, result and host enable.
  assumes host pins are asynchronous and the converter core result is on aclk.
*/
// Local design decisions: the register addresses and register access over AXI4-Lite.
module das_host_bus_control (
  input wire logic aclk,
  input wire logic aresetn,
  // host side pins
  input wire logic host_wr_n,
  input wire logic host_rd_n,
  input wire logic host_sel_n,
  input wire logic host_addr_hi,
  input wire logic byte_format_select,
  input wire logic [das_pkg::CHAN_W-1:0] host_data_in,
  output logic [das_pkg::BYTE_W-1:0] host_data_out,
  output logic host_data_oe,
  output logic conversion_status,
  // converter core side
  output logic channel_addr_bit0,
  output logic channel_addr_bit1,
  output logic channel_addr_bit2,
  output logic conv_start,
  output logic conv_short,
  input wire logic [das_pkg::RESULT_W-1:0] conv_result,
  // axi4-lite slave
  input wire logic [das_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [das_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // ==========================================================
  // host pin synchronisers
  logic [das_pkg::SYNC_W-1:0] pins;
  logic [das_pkg::SYNC_W-1:0] sy;

  assign pins = {host_data_in, byte_format_select, host_addr_hi, host_sel_n, host_rd_n, host_wr_n};

  pin_sync #(.W(das_pkg::SYNC_W), .INIT(das_pkg::SYNC_INIT)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(pins),
    .stable(sy)
  );

  // ==========================================================
  // conversion and host decode state
  das_pkg::conv_state_t state_q, state_d;
  logic [das_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [das_pkg::CHAN_W-1:0] chan_q, chan_d;
  logic [das_pkg::RESULT_W-1:0] result_q, result_d;
  logic short_q, short_d;
  logic wr_prev_q, wr_prev_d;
  logic start_q, start_d;
  logic [das_pkg::BYTE_W-1:0] dout_q, dout_d;
  logic oe_q, oe_d;
  logic ev_done, ev_overlap;
  logic host_en_q;
  logic wr_rise;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    chan_d = chan_q;
    result_d = result_q;
    short_d = short_q;
    start_d = 1'b0;
    ev_done = 1'b0;
    ev_overlap = 1'b0;
    wr_prev_d = sy[das_pkg::SY_WR];
    // RQ4 write on rising strobe
    wr_rise = !wr_prev_q && sy[das_pkg::SY_WR] && !sy[das_pkg::SY_SEL] && host_en_q;
    if (state_q == das_pkg::ST_CONV) begin
      if (cnt_q == das_pkg::CNT_LAST) begin
        state_d = das_pkg::ST_IDLE;
        ev_done = 1'b1;
        // short cycle leaves the low nibble at zero
        result_d = short_q ? {conv_result[das_pkg::RESULT_W-1:das_pkg::LOW_NIB_W], das_pkg::ZERO_NIB}
                           : conv_result;
      end else begin
        cnt_d = cnt_q - das_pkg::CNT_LAST;
      end
    end
    if (wr_rise) begin
      if (!sy[das_pkg::SY_AHI]) begin
        // RQ8 low address latches channel
        chan_d = sy[das_pkg::SY_DAT +: das_pkg::CHAN_W];
        // RQ11 overlap channel select
        ev_overlap = (state_q == das_pkg::ST_CONV);
      end else if (state_q == das_pkg::ST_IDLE) begin
        // RQ1 length from format select
        short_d = sy[das_pkg::SY_BFS];
        cnt_d = sy[das_pkg::SY_BFS] ? das_pkg::CONV8_CYC : das_pkg::CONV12_CYC;
        state_d = das_pkg::ST_CONV;
        start_d = 1'b1;
      end
    end
    // RQ10 release bus outside reads
    oe_d = !sy[das_pkg::SY_RD] && !sy[das_pkg::SY_SEL] && host_en_q;
    if (sy[das_pkg::SY_BFS]) begin
      // RQ3 low nibble then zeros
      dout_d = {result_q[das_pkg::LOW_NIB_W-1:0], das_pkg::ZERO_NIB};
    end else begin
      // RQ2 eight top bits
      dout_d = result_q[das_pkg::RESULT_W-1:das_pkg::LOW_NIB_W];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= das_pkg::ST_IDLE;
      cnt_q <= '0;
      chan_q <= '0;
      result_q <= '0;
      short_q <= 1'b0;
      wr_prev_q <= 1'b1;
      start_q <= 1'b0;
      dout_q <= '0;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      chan_q <= chan_d;
      result_q <= result_d;
      short_q <= short_d;
      wr_prev_q <= wr_prev_d;
      start_q <= start_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
    end
  end

  assign host_data_out = dout_q;
  assign host_data_oe = oe_q;
  assign conversion_status = logic'(state_q);
  assign channel_addr_bit0 = chan_q[0];
  assign channel_addr_bit1 = chan_q[1];
  assign channel_addr_bit2 = chan_q[2];
  assign conv_start = start_q;
  assign conv_short = short_q;

  // ==========================================================
  // axi4-lite slave and register file
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
  logic [das_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [das_pkg::EV_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
  logic host_en_d;
  logic irq_q, irq_d;
  logic do_wr;

  // unmapped or misaligned words answer slverr
  function automatic logic known(input logic [das_pkg::ADDR_W-1:0] a);
    known = (a == das_pkg::OFF_STATUS) || (a == das_pkg::OFF_MASK) ||
            (a == das_pkg::OFF_RESULT) || (a == das_pkg::OFF_CONTROL);
  endfunction

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    bv_d = bv_q;
    bresp_d = bresp_q;
    rv_d = rv_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    mask_d = mask_q;
    host_en_d = host_en_q;
    awr_d = 1'b0;
    wr_d = 1'b0;
    arr_d = 1'b0;
    ev = '0;
    ev[das_pkg::EV_DONE] = ev_done;
    ev[das_pkg::EV_OVERLAP] = ev_overlap;
    stat_d = stat_q;
    if (s_axi_awvalid && !aw_q && !awr_q) begin
      awr_d = 1'b1;
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !wr_q) begin
      wr_d = 1'b1;
      w_d = 1'b1;
      wdata_d = s_axi_wdata;
    end
    do_wr = aw_q && w_q && !bv_q;
    if (do_wr) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      bresp_d = known(awaddr_q) ? das_pkg::RESP_OKAY : das_pkg::RESP_SLVERR;
      if (awaddr_q == das_pkg::OFF_STATUS) begin
        stat_d = stat_q & ~wdata_q[das_pkg::EV_W-1:0];
      end else if (awaddr_q == das_pkg::OFF_MASK) begin
        mask_d = wdata_q[das_pkg::EV_W-1:0];
      end else if (awaddr_q == das_pkg::OFF_CONTROL) begin
        host_en_d = wdata_q[das_pkg::CTL_HOST_EN];
      end
    end
    // a new event wins over a clear in the same cycle
    stat_d = stat_d | ev;
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (s_axi_arvalid && !rv_q && !arr_q) begin
      arr_d = 1'b1;
      rv_d = 1'b1;
      rresp_d = known(s_axi_araddr) ? das_pkg::RESP_OKAY : das_pkg::RESP_SLVERR;
      rdata_d = '0;
      if (s_axi_araddr == das_pkg::OFF_STATUS) begin
        rdata_d[das_pkg::EV_W-1:0] = stat_q;
      end else if (s_axi_araddr == das_pkg::OFF_MASK) begin
        rdata_d[das_pkg::EV_W-1:0] = mask_q;
      end else if (s_axi_araddr == das_pkg::OFF_RESULT) begin
        rdata_d[das_pkg::RESULT_W-1:0] = result_q;
        rdata_d[das_pkg::RES_CHAN_LSB +: das_pkg::CHAN_W] = chan_q;
        rdata_d[das_pkg::RES_SHORT_BIT] = short_q;
        rdata_d[das_pkg::RES_BUSY_BIT] = (state_q == das_pkg::ST_CONV);
      end else if (s_axi_araddr == das_pkg::OFF_CONTROL) begin
        rdata_d[das_pkg::CTL_HOST_EN] = host_en_q;
      end
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      arr_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      bv_q <= 1'b0;
      bresp_q <= das_pkg::RESP_OKAY;
      rv_q <= 1'b0;
      rresp_q <= das_pkg::RESP_OKAY;
      rdata_q <= '0;
      stat_q <= '0;
      mask_q <= '0;
      host_en_q <= das_pkg::CTL_HOST_EN_RST;
      irq_q <= 1'b0;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      awr_q <= awr_d;
      wr_q <= wr_d;
      arr_q <= arr_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      bv_q <= bv_d;
      bresp_q <= bresp_d;
      rv_q <= rv_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      host_en_q <= host_en_d;
      irq_q <= irq_d;
    end
  end

  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign irq = irq_q;

endmodule

/* test/das_props.sv */
/*
  concurrent checks on the host bus control ports.
  assumes one clock domain and a host that holds its pins steady around each strobe.
*/
module das_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic host_wr_n,
  input wire logic host_rd_n,
  input wire logic host_addr_hi,
  input wire logic byte_format_select,
  input wire logic [2:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  input wire logic conversion_status,
  input wire logic channel_addr_bit0,
  input wire logic channel_addr_bit1,
  input wire logic channel_addr_bit2,
  input wire logic conv_start,
  input wire logic conv_short,
  input wire logic [11:0] conv_result,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [8:0] cnt_q, cnt_d;
  logic [11:0] res_q, res_d;
  wire [2:0] chan = {channel_addr_bit2, channel_addr_bit1, channel_addr_bit0};
  // ========
  // busy length and last sampled result
  always_comb begin
    cnt_d = conversion_status ? cnt_q + 9'h001 : 9'h000;
    res_d = conversion_status ? conv_result : res_q;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 9'h000;
      res_q <= 12'h000;
    end else begin
      cnt_q <= cnt_d;
      res_q <= res_d;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // strobe pins pass a few sync flops, so a window is looked at, not an edge
  sequence s_wr_edge;
    $past(host_wr_n, 3) && !$past(host_wr_n, 7);
  endsequence
  sequence s_steady(logic b);
    (byte_format_select == b && !conversion_status) [*7];
  endsequence
  property p_len;
    $fell(conversion_status) |-> cnt_q == (conv_short ? das_pkg::CONV8_CYC : das_pkg::CONV12_CYC);
  endproperty
  property p_start;
    conv_start |-> s_wr_edge ##0 (conversion_status && !$past(conversion_status) && $past(host_addr_hi, 4));
  endproperty
  property p_pulse;
    conv_start |=> (!conv_start && conversion_status) [*8];
  endproperty
  property p_chan;
    $changed(chan) |-> s_wr_edge ##0 (!$past(host_addr_hi, 4) && chan == $past(host_data_in, 4));
  endproperty
  property p_release;
    host_rd_n [*7] |-> !host_data_oe;
  endproperty
  property p_top;
    s_steady(1'b0) ##0 host_data_oe |-> host_data_out == res_q[11:4];
  endproperty
  property p_low;
    s_steady(1'b1) ##0 host_data_oe |-> host_data_out == (conv_short ? 8'h00 : {res_q[3:0], 4'h0});
  endproperty
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  a_start: assert property (p_start) else $error("start without write edge");
  a_pulse: assert property (p_pulse) else $error("start pulse or status wrong");
  a_chan: assert property (p_chan) else $error("channel changed wrongly");
  a_release: assert property (p_release) else $error("data bus not released");
  a_top: assert property (p_top) else $error("top byte wrong");
  a_low: assert property (p_low) else $error("low byte wrong");
  a_rhold: assert property (p_rhold) else $error("read data not held");
endmodule
bind das_host_bus_control das_props i_props (
  .aclk(aclk),
  .aresetn(aresetn),
  .host_wr_n(host_wr_n),
  .host_rd_n(host_rd_n),
  .host_addr_hi(host_addr_hi),
  .byte_format_select(byte_format_select),
  .host_data_in(host_data_in),
  .host_data_out(host_data_out),
  .host_data_oe(host_data_oe),
  .conversion_status(conversion_status),
  .channel_addr_bit0(channel_addr_bit0),
  .channel_addr_bit1(channel_addr_bit1),
  .channel_addr_bit2(channel_addr_bit2),
  .conv_start(conv_start),
  .conv_short(conv_short),
  .conv_result(conv_result),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);

/* test/host_cpu_model.sv */
/*
  8-bit host cpu model driving memory-mapped strobes.
  assumes the bench calls one task at a time.
*/
module host_cpu_model (
  input wire logic aclk,
  output logic host_wr_n,
  output logic host_rd_n,
  output logic host_sel_n,
  output logic host_addr_hi,
  output logic byte_format_select,
  output logic [2:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe
);
  initial begin
    host_wr_n = 1'b1;
    host_rd_n = 1'b1;
    host_sel_n = 1'b1;
    host_addr_hi = 1'b0;
    byte_format_select = 1'b0;
    host_data_in = 3'h5;
  end
  task automatic wr(input logic hi, input logic bfs, input logic [2:0] d);
    @(posedge aclk);
    host_sel_n <= 1'b0;
    host_addr_hi <= hi;
    byte_format_select <= bfs;
    host_data_in <= d;
    repeat (2) @(posedge aclk);
    host_wr_n <= 1'b0;
    repeat (8) @(posedge aclk);
    host_wr_n <= 1'b1;
    repeat (8) @(posedge aclk);
    host_sel_n <= 1'b1;
    // released lines must not keep a stale value
    host_data_in <= ~d;
  endtask
  task automatic rd(input logic bfs, output logic [7:0] q, output logic oe);
    @(posedge aclk);
    host_sel_n <= 1'b0;
    byte_format_select <= bfs;
    host_rd_n <= 1'b0;
    repeat (10) @(posedge aclk);
    q = host_data_out;
    oe = host_data_oe;
    host_rd_n <= 1'b1;
    host_sel_n <= 1'b1;
  endtask
endmodule

/* test/das_host_bus_control_test.sv */
/*
  self-checking bench for the host bus control.
  assumes a 10 MHz clock and the host cpu model on the strobe pins.
*/
module das_host_bus_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, host_wr_n, host_rd_n, host_sel_n, host_addr_hi, byte_format_select;
  logic host_data_oe, conversion_status, channel_addr_bit0, channel_addr_bit1, channel_addr_bit2;
  logic conv_start, conv_short, irq;
  logic [2:0] host_data_in;
  logic [7:0] host_data_out;
  logic [11:0] conv_result;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire [2:0] chan = {channel_addr_bit2, channel_addr_bit1, channel_addr_bit0};
  int seed = 48;
  int miscompares = 0;
  int total_checks = 0;
  int run_len = 0;
  int last_len = 0;
  int starts = 0;
  das_host_bus_control i_dut (.*);
  host_cpu_model i_host (.*);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    run_len <= conversion_status ? run_len + 1 : 0;
    if (!conversion_status && run_len != 0) last_len <= run_len;
    if (conv_start) starts <= starts + 1;
  end
  // ========
  // expectations and bus tasks
  function automatic int conv_len(input logic short);
    return short ? 25000 / 100 : 35000 / 100;
  endfunction
  function automatic logic [7:0] low_read(input logic [11:0] r, input logic short);
    return short ? 8'h00 : {r[3:0], 4'h0};
  endfunction
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, das_pkg::RESP_OKAY);
  endtask
  task axi_rd(input logic [3:0] a, input logic [1:0] resp, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        // late rready makes the slave hold its answer for a cycle
        s_axi_rready <= 1'b1;
      end
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", s_axi_rresp, resp);
  endtask
  task report_and_stop;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    report_and_stop;
  end
  // ========
  // main sequence
  initial begin
    logic [7:0] q;
    logic oe, s;
    logic [31:0] d;
    logic [11:0] res;
    logic [2:0] ch;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, conv_result} = 52'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    axi_rd(das_pkg::OFF_CONTROL, das_pkg::RESP_OKAY, d);
    chk("control", d, 32'h0000_0001);
    axi_rd(4'h6, das_pkg::RESP_SLVERR, d);
    chk("unmapped", d, 32'h0);
    for (int i = 0; i < 4; i++) begin
      s = i[0];
      res = 12'($random(seed));
      ch = 3'($random(seed));
      conv_result <= res;
      axi_wr(das_pkg::OFF_MASK, {31'h0, i[1]});
      i_host.wr(1'b0, 1'b0, ch);
      chk("channel", chan, ch);
      repeat (100) @(posedge aclk);
      i_host.wr(1'b1, s, ~ch);
      chk("busy", conversion_status, 1'b1);
      chk("short", conv_short, s);
      i_host.wr(1'b0, 1'b0, ch + 3'h1);
      chk("overlap", {conversion_status, chan}, {1'b1, ch + 3'h1});
      i_host.wr(1'b1, ~s, ch);
      chk("refused", {conversion_status, conv_short}, {1'b1, s});
      if (i[1]) begin
        repeat (conv_len(1'b0)) @(posedge aclk);
      end else begin
        while (conversion_status) @(posedge aclk);
      end
      repeat (3) @(posedge aclk);
      chk("length", last_len, conv_len(s));
      chk("irq", irq, i[1]);
      i_host.rd(1'b0, q, oe);
      chk("top", q, res[11:4]);
      i_host.rd(1'b1, q, oe);
      chk("low", {oe, q}, {1'b1, low_read(res, s)});
      repeat (8) @(posedge aclk);
      chk("released", host_data_oe, 1'b0);
      axi_rd(das_pkg::OFF_RESULT, das_pkg::RESP_OKAY, d);
      chk("result", d & 32'h8fff, {16'h0, s, 3'h0, s ? {res[11:4], 4'h0} : res});
      axi_rd(das_pkg::OFF_STATUS, das_pkg::RESP_OKAY, d);
      chk("events", d, 32'h3);
      axi_wr(das_pkg::OFF_STATUS, 32'h3);
      repeat (2) @(posedge aclk);
      chk("irq clear", irq, 1'b0);
      axi_rd(das_pkg::OFF_STATUS, das_pkg::RESP_OKAY, d);
      chk("events clear", d, 32'h0);
    end
    // host strobes ignored while disabled
    axi_wr(das_pkg::OFF_CONTROL, 32'h0);
    i_host.wr(1'b0, 1'b0, ~chan);
    i_host.wr(1'b1, 1'b0, 3'h0);
    chk("disabled", {conversion_status, chan}, {1'b0, ch + 3'h1});
    i_host.rd(1'b0, q, oe);
    chk("disabled read", oe, 1'b0);
    axi_wr(das_pkg::OFF_CONTROL, 32'h1);
    chk("starts", starts, 32'h4);
    report_and_stop;
  end
endmodule
